// >>> iopx_exec.sv
// port input/output instruction executor: single and block transfers
`timescale 1ns/1ns
module iopx_exec
	import iopx_pkg::*;
#(
	parameter bit BUS8 = 1'b0
)(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic start,
	input wire iopx_op_e op,
	input wire logic width_bit,
	input wire logic repeat_prefix,
	input wire logic [7:0] imm8,
	input wire logic seg_override,
	input wire logic [15:0] override_segment,
	input wire logic [15:0] accumulator_word,
	input wire logic [15:0] port_pointer_reg,
	input wire logic [15:0] source_index,
	input wire logic [15:0] dest_index,
	input wire logic [15:0] source_segment,
	input wire logic [15:0] dest_segment,
	input wire logic [15:0] count_reg,
	input wire logic direction_flag,
	output logic busy,
	output logic done,
	output logic acc_wr,
	output logic acc_high_wr,
	output logic [15:0] acc_result,
	output logic index_wr,
	output logic [15:0] index_result,
	output logic count_wr,
	output logic [15:0] count_result,
	output logic io_req,
	output logic io_we,
	output logic io_word,
	output logic [15:0] io_addr,
	output logic [15:0] io_wdata,
	input wire logic [15:0] io_rdata,
	input wire logic io_ack,
	output logic mem_req,
	output logic mem_we,
	output logic mem_word,
	output logic [15:0] mem_seg,
	output logic [15:0] mem_off,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack
);
	iopx_state_e state_reg, state_next;
	iopx_op_e op_reg, op_next;
	logic word_reg, word_next;
	logic rep_reg, rep_next;
	logic half_reg, half_next;
	logic first_reg, first_next;
	logic [15:0] port_reg, port_next;
	logic [15:0] idx_reg, idx_next;
	logic [15:0] seg_reg, seg_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [15:0] data_reg, data_next;
	logic [15:0] addr_reg, addr_next;
	logic [15:0] wdata_reg, wdata_next;
	logic done_reg, done_next;
	logic acc_wr_reg, acc_wr_next;
	logic idx_wr_reg, idx_wr_next;
	logic cnt_wr_reg, cnt_wr_next;
	logic t_load;
	logic [CNT_W-1:0] t_val;
	logic t_exp;
	logic is_block, is_input, io_split, mem_split, split_now, ack_now;

	// clocks for one block element given port and memory alignment
	function automatic logic [CNT_W-1:0] elem_clks(input logic w, input logic po,
		input logic mo);
		if (!w) begin
			elem_clks = CLK_ELEM_FAST;
		end else if (BUS8 || (po && mo)) begin
			elem_clks = CLK_ELEM_SLOW;
		end else if (po ^ mo) begin
			elem_clks = CLK_ELEM_MIXED;
		end else begin
			elem_clks = CLK_ELEM_FAST;
		end
	endfunction

	// a word goes as two byte cycles on the narrow bus or at an odd address
	function automatic logic needs_split(input logic w, input logic [15:0] a);
		needs_split = w && (BUS8 || a[0]);
	endfunction

	assign is_block = (op_reg == OP_BLOCK_IN) || (op_reg == OP_BLOCK_OUT);
	assign is_input = (op_reg == OP_IN_DIRECT) || (op_reg == OP_IN_INDIR)
		|| (op_reg == OP_BLOCK_IN);
	assign io_split = needs_split(word_reg, port_reg);
	assign mem_split = needs_split(word_reg, idx_reg);
	assign split_now = (state_reg == ST_IO) ? io_split : mem_split;
	assign ack_now = (state_reg == ST_IO) ? io_ack : mem_ack;

	iopx_timer u_timer (
		.mclk(mclk),
		.rst_b(rst_b),
		.ce(ce),
		.load(t_load),
		.load_val(t_val),
		.expired(t_exp)
	);

	always_comb begin
		logic in_op, blk, w, sp;
		logic [15:0] pa, ia;
		in_op = 1'b0;
		blk = 1'b0;
		w = 1'b0;
		sp = 1'b0;
		pa = '0;
		ia = '0;
		state_next = state_reg;
		op_next = op_reg;
		word_next = word_reg;
		rep_next = rep_reg;
		half_next = half_reg;
		first_next = first_reg;
		port_next = port_reg;
		idx_next = idx_reg;
		seg_next = seg_reg;
		cnt_next = cnt_reg;
		data_next = data_reg;
		done_next = 1'b0;
		acc_wr_next = 1'b0;
		idx_wr_next = 1'b0;
		cnt_wr_next = 1'b0;
		t_load = 1'b0;
		t_val = '0;
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					in_op = (op == OP_IN_DIRECT) || (op == OP_IN_INDIR) || (op == OP_BLOCK_IN);
					blk = (op == OP_BLOCK_IN) || (op == OP_BLOCK_OUT);
					w = width_bit;
					pa = ((op == OP_IN_DIRECT) || (op == OP_OUT_DIRECT))
						? {8'h00, imm8} : port_pointer_reg;
					ia = (op == OP_BLOCK_IN) ? dest_index : source_index;
					sp = needs_split(w, pa);
					op_next = op;
					word_next = w;
					rep_next = blk && repeat_prefix;
					port_next = pa;
					idx_next = ia;
					cnt_next = count_reg;
					half_next = 1'b0;
					first_next = 1'b1;
					data_next = accumulator_word;
					// input always lands in dest_segment; only output takes an override
					seg_next = (op == OP_BLOCK_IN) ? dest_segment
						: (seg_override ? override_segment : source_segment);
					t_load = 1'b1;
					if (blk && repeat_prefix) begin
						t_val = CLK_REP_SETUP;
						state_next = ST_SETUP;
					end else if (blk) begin
						t_val = elem_clks(w, pa[0], ia[0]) + CLK_SINGLE_EXTRA;
						state_next = (op == OP_BLOCK_IN) ? ST_IO : ST_MEM;
					end else begin
						if (op == OP_IN_DIRECT) begin
							t_val = sp ? CLK_DIRECT_SPLIT : CLK_DIRECT_BYTE;
						end else begin
							t_val = sp ? CLK_INDIR_SPLIT : CLK_INDIR_BYTE;
						end
						state_next = ST_IO;
					end
					if (!in_op) begin
						data_next = accumulator_word;
					end
				end
			end
			ST_SETUP: begin
				if (t_exp) begin
					if (cnt_reg == '0) begin
						state_next = ST_DONE;
					end else begin
						t_load = 1'b1;
						t_val = elem_clks(word_reg, port_reg[0], idx_reg[0]);
						first_next = 1'b1;
						half_next = 1'b0;
						state_next = (op_reg == OP_BLOCK_IN) ? ST_IO : ST_MEM;
					end
				end
			end
			ST_IO, ST_MEM: begin
				if (ack_now) begin
					if (is_input && (state_reg == ST_IO)) begin
						if (!split_now) begin
							data_next = word_reg ? io_rdata : {8'h00, io_rdata[7:0]};
						end else if (!half_reg) begin
							data_next[7:0] = io_rdata[7:0];
						end else begin
							data_next[15:8] = io_rdata[7:0];
						end
					end
					if (!is_input && (state_reg == ST_MEM)) begin
						if (!split_now) begin
							data_next = word_reg ? mem_rdata : {8'h00, mem_rdata[7:0]};
						end else if (!half_reg) begin
							data_next[7:0] = mem_rdata[7:0];
						end else begin
							data_next[15:8] = mem_rdata[7:0];
						end
					end
					if (split_now && !half_reg) begin
						half_next = 1'b1;
					end else begin
						half_next = 1'b0;
						// second bus side of the element: port then memory or reverse
						if (is_block && first_reg) begin
							first_next = 1'b0;
							state_next = (state_reg == ST_IO) ? ST_MEM : ST_IO;
						end else begin
							state_next = ST_WAIT;
						end
					end
				end
			end
			ST_WAIT: begin
				if (t_exp) begin
					if (!is_block) begin
						acc_wr_next = is_input;
						state_next = ST_DONE;
					end else begin
						idx_next = direction_flag
							? idx_reg - (word_reg ? STEP_WORD : STEP_BYTE)
							: idx_reg + (word_reg ? STEP_WORD : STEP_BYTE);
						idx_wr_next = 1'b1;
						if (rep_reg) begin
							cnt_next = cnt_reg - 16'h0001;
							cnt_wr_next = 1'b1;
							if (cnt_reg == 16'h0001) begin
								state_next = ST_DONE;
							end else begin
								t_load = 1'b1;
								t_val = elem_clks(word_reg, port_reg[0], idx_next[0]);
								first_next = 1'b1;
								state_next = (op_reg == OP_BLOCK_IN) ? ST_IO : ST_MEM;
							end
						end else begin
							state_next = ST_DONE;
						end
					end
				end
			end
			ST_DONE: begin
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// bus address and write data for the access being entered
	always_comb begin
		logic sp;
		sp = (state_next == ST_IO) ? needs_split(word_next, port_next)
			: needs_split(word_next, idx_next);
		if (state_next == ST_IO) begin
			addr_next = port_next + {15'h0000, half_next};
		end else begin
			addr_next = idx_next + {15'h0000, half_next};
		end
		if (sp) begin
			wdata_next = {8'h00, half_next ? data_next[15:8] : data_next[7:0]};
		end else begin
			wdata_next = data_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_IN_DIRECT;
			word_reg <= 1'b0;
			rep_reg <= 1'b0;
			half_reg <= 1'b0;
			first_reg <= 1'b0;
			port_reg <= '0;
			idx_reg <= '0;
			seg_reg <= '0;
			cnt_reg <= '0;
			data_reg <= '0;
			addr_reg <= '0;
			wdata_reg <= '0;
			done_reg <= 1'b0;
			acc_wr_reg <= 1'b0;
			idx_wr_reg <= 1'b0;
			cnt_wr_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			op_reg <= op_next;
			word_reg <= word_next;
			rep_reg <= rep_next;
			half_reg <= half_next;
			first_reg <= first_next;
			port_reg <= port_next;
			idx_reg <= idx_next;
			seg_reg <= seg_next;
			cnt_reg <= cnt_next;
			data_reg <= data_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			done_reg <= done_next;
			acc_wr_reg <= acc_wr_next;
			idx_wr_reg <= idx_wr_next;
			cnt_wr_reg <= cnt_wr_next;
		end
	end

	// no flag outputs exist: arithmetic flags are never touched
	assign busy = (state_reg != ST_IDLE);
	assign done = done_reg;
	assign acc_wr = acc_wr_reg;
	assign acc_high_wr = acc_wr_reg && word_reg;
	assign acc_result = data_reg;
	assign index_wr = idx_wr_reg;
	assign index_result = idx_reg;
	assign count_wr = cnt_wr_reg;
	assign count_result = cnt_reg;
	assign io_req = (state_reg == ST_IO);
	assign io_we = !is_input;
	assign io_word = word_reg && !io_split;
	assign io_addr = addr_reg;
	assign io_wdata = wdata_reg;
	assign mem_req = (state_reg == ST_MEM);
	assign mem_we = is_input;
	assign mem_word = word_reg && !mem_split;
	assign mem_seg = seg_reg;
	assign mem_off = addr_reg;
	assign mem_wdata = wdata_reg;
endmodule

// >>> iopx_timer.sv
// package of constants and the cycle budget timer for the port i/o executor
`timescale 1ns/1ns
package iopx_pkg;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CLK_DIRECT_BYTE = 5'd9;
	localparam logic [CNT_W-1:0] CLK_DIRECT_SPLIT = 5'd13;
	localparam logic [CNT_W-1:0] CLK_INDIR_BYTE = 5'd8;
	localparam logic [CNT_W-1:0] CLK_INDIR_SPLIT = 5'd12;
	localparam logic [CNT_W-1:0] CLK_REP_SETUP = 5'd9;
	localparam logic [CNT_W-1:0] CLK_ELEM_FAST = 5'd8;
	localparam logic [CNT_W-1:0] CLK_ELEM_MIXED = 5'd12;
	localparam logic [CNT_W-1:0] CLK_ELEM_SLOW = 5'd16;
	localparam logic [CNT_W-1:0] CLK_SINGLE_EXTRA = 5'd2;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	typedef enum logic [2:0] {
		OP_IN_DIRECT = 3'h0,
		OP_IN_INDIR = 3'h1,
		OP_OUT_DIRECT = 3'h2,
		OP_OUT_INDIR = 3'h3,
		OP_BLOCK_IN = 3'h4,
		OP_BLOCK_OUT = 3'h5
	} iopx_op_e;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_SETUP = 6'b000010,
		ST_IO = 6'b000100,
		ST_MEM = 6'b001000,
		ST_WAIT = 6'b010000,
		ST_DONE = 6'b100000
	} iopx_state_e;
endpackage

module iopx_timer
	import iopx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic load,
	input wire logic [CNT_W-1:0] load_val,
	output logic expired
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		if (load) begin
			cnt_next = load_val - CNT_W'(1);
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - CNT_W'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
		end else if (ce) begin
			cnt_reg <= cnt_next;
		end
	end

	// no load term: the loader decides on expired, a load term would close a loop
	assign expired = (cnt_reg == '0);
endmodule

// >>> iopx_exec_asserts.sv
// checker of executor handshakes and timing
`timescale 1ns/1ns
module iopx_exec_asserts (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic start,
	input wire logic busy,
	input wire logic done,
	input wire logic acc_wr,
	input wire logic acc_high_wr,
	input wire logic io_req,
	input wire logic io_ack,
	input wire logic io_we,
	input wire logic [15:0] io_addr,
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic [15:0] mem_off
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence take_s;
		ce && start && !busy;
	endsequence
	sequence no_done_s;
		!done [*6];
	endsequence
	done_pulse_a: assert property (done |=> !done) else $error("done too long");
	min_budget_a: assert property (take_s |=> no_done_s) else $error("done early");
	done_bound_a: assert property (take_s |-> ##[1:400] done) else $error("no done");
	io_hold_a: assert property (io_req && !io_ack |=> io_req && $stable(io_addr)
		&& $stable(io_we)) else $error("io request moved");
	mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_off))
		else $error("mem request moved");
	idle_quiet_a: assert property (!busy |-> !io_req && !mem_req) else $error("idle bus");
	acc_done_a: assert property (acc_wr |=> done) else $error("acc write not last");
	high_pair_a: assert property (acc_high_wr |-> acc_wr) else $error("lone high write");
	done_free_a: assert property (done |-> !io_req && !mem_req) else $error("bus at done");
endmodule

// >>> iopx_peer.sv
// port devices and memory answering both buses
`timescale 1ns/1ns
module iopx_peer (
	input wire logic mclk,
	input wire logic slow,
	input wire logic io_req,
	input wire logic io_we,
	input wire logic io_word,
	input wire logic [15:0] io_addr,
	input wire logic [15:0] io_wdata,
	output logic [15:0] io_rdata,
	output logic io_ack,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_word,
	input wire logic [15:0] mem_off,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	logic [7:0] port [256];
	logic [7:0] mem [256];
	logic [15:0] junk = 16'h0000;
	int io_n = 0;
	int mem_n = 0;
	int wt = 0;
	initial io_ack = 1'b0;
	initial mem_ack = 1'b0;
	// read data churns outside acks so a late sample shows garbage
	always @(posedge mclk) begin
		junk <= junk + 16'h1357;
		io_ack <= 1'b0;
		mem_ack <= 1'b0;
		io_rdata <= ~junk;
		mem_rdata <= junk;
		if (!(io_req || mem_req) || io_ack || mem_ack) wt <= 0;
		else if (wt < (slow ? 3 : 0)) wt <= wt + 1;
		else if (io_req) begin
			io_ack <= 1'b1;
			io_n++;
			io_rdata <= {(io_addr[7:0] + 8'h01) ^ 8'h5a, io_addr[7:0] ^ 8'h5a};
			if (io_we) port[io_addr[7:0]] <= io_wdata[7:0];
			if (io_we && io_word) port[io_addr[7:0] + 8'h01] <= io_wdata[15:8];
		end else begin
			mem_ack <= 1'b1;
			mem_n++;
			mem_rdata <= {mem[mem_off[7:0] + 8'h01], mem[mem_off[7:0]]};
			if (mem_we) mem[mem_off[7:0]] <= mem_wdata[7:0];
			if (mem_we && mem_word) mem[mem_off[7:0] + 8'h01] <= mem_wdata[15:8];
		end
	end
endmodule

// >>> tb_top.sv
// self-checking bench for the port i/o executor
`timescale 1ns/1ns
module tb_top;
	import iopx_pkg::*;
	logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, start = 1'b0, width_bit = 1'b0, slow = 1'b0;
	logic repeat_prefix = 1'b0, seg_override = 1'b0, direction_flag = 1'b0, hi_cap;
	iopx_op_e op = OP_IN_DIRECT;
	logic [7:0] imm8 = 8'h00;
	logic [15:0] override_segment = 16'h0000, accumulator_word = 16'h0000;
	logic [15:0] port_pointer_reg = 16'h0000, source_index = 16'h0000, dest_index = 16'h0000;
	logic [15:0] source_segment = 16'h1000, dest_segment = 16'h0000, count_reg = 16'h0000;
	logic [15:0] io_rdata, mem_rdata, acc_result, index_result, count_result, io_addr, io_wdata;
	logic [15:0] mem_seg, mem_off, mem_wdata, acc_cap, idx_cap, cnt_cap, seg_cap;
	logic io_ack, mem_ack, busy, done, acc_wr, acc_high_wr, index_wr, count_wr;
	logic io_req, io_we, io_word, mem_req, mem_we, mem_word;
	int bad_count = 0;
	int compares = 0;
	int cyc;
	iopx_exec #(.BUS8(1'b0)) dut_u (.*);
	iopx_peer peer_u (.*);
	initial forever #20 mclk = ~mclk;
	always @(negedge mclk) begin
		if (acc_wr === 1'b1) acc_cap <= acc_result;
		if (acc_wr === 1'b1) hi_cap <= acc_high_wr;
		if (index_wr === 1'b1) idx_cap <= index_result;
		if (count_wr === 1'b1) cnt_cap <= count_result;
		if (mem_req === 1'b1) seg_cap <= mem_seg;
	end
	function automatic logic [7:0] pd(input logic [15:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic run(input iopx_op_e o, input logic w, input logic rp);
		@(negedge mclk);
		op = o;
		width_bit = w;
		repeat_prefix = rp;
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
		cyc = 0;
		while (done !== 1'b1 && cyc < 600) begin
			@(negedge mclk);
			cyc++;
		end
		chk({15'h0, done}, 16'h0001);
	endtask
	// prompt acks only: done lands one cycle after the budget runs out
	task automatic bud(input int n);
		chk(16'(cyc), 16'(n + 1));
	endtask
	task automatic t_in;
		logic [15:0] a;
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 16'h0020 : (i == 1) ? 16'h0021 : (i == 2) ? 16'h0048 : 16'h0301;
			imm8 = a[7:0];
			port_pointer_reg = a;
			run((i == 3) ? OP_IN_INDIR : OP_IN_DIRECT, i != 0, 1'b0);
			bud((i == 1) ? 13 : (i == 3) ? 12 : 9);
			if (i == 0) chk({8'h00, acc_cap[7:0]}, {8'h00, pd(a)});
			else chk(acc_cap, {pd(a + 16'h0001), pd(a)});
			chk({15'h0, hi_cap}, {15'h0, i != 0});
		end
	endtask
	task automatic t_out;
		accumulator_word = 16'hc3a5;
		imm8 = 8'h30;
		run(OP_OUT_DIRECT, 1'b1, 1'b0);
		bud(8);
		chk({peer_u.port[8'h31], peer_u.port[8'h30]}, 16'hc3a5);
		port_pointer_reg = 16'h0205;
		run(OP_OUT_INDIR, 1'b1, 1'b0);
		bud(12);
		chk({peer_u.port[8'h06], peer_u.port[8'h05]}, 16'hc3a5);
	endtask
	task automatic t_bin;
		int n0;
		n0 = peer_u.io_n + peer_u.mem_n;
		port_pointer_reg = 16'h0010;
		dest_index = 16'h0080;
		dest_segment = 16'h2000;
		count_reg = 16'h0003;
		direction_flag = 1'b1;
		seg_override = 1'b0;
		run(OP_BLOCK_IN, 1'b0, 1'b1);
		bud(33);
		for (int k = 0; k < 3; k++) chk({8'h00, peer_u.mem[8'(128 - k)]}, 16'h004a);
		chk(idx_cap, 16'h007d);
		chk(cnt_cap, 16'h0000);
		chk(seg_cap, 16'h2000);
		chk(16'(peer_u.io_n + peer_u.mem_n - n0), 16'h0006);
		n0 = peer_u.io_n;
		count_reg = 16'h0000;
		run(OP_BLOCK_IN, 1'b0, 1'b1);
		bud(9);
		chk(16'(peer_u.io_n - n0), 16'h0000);
		// single word element, odd port and even memory
		port_pointer_reg = 16'h0011;
		dest_index = 16'h0090;
		direction_flag = 1'b0;
		run(OP_BLOCK_IN, 1'b1, 1'b0);
		bud(14);
		chk({peer_u.mem[8'h91], peer_u.mem[8'h90]}, {pd(16'h0012), pd(16'h0011)});
		chk(idx_cap, 16'h0092);
	endtask
	task automatic t_bout;
		for (int k = 0; k < 4; k++) peer_u.mem[8'(64 + k)] = 8'(17 * (k + 1));
		peer_u.mem[8'h60] = 8'h5e;
		slow = 1'b1;
		source_index = 16'h0040;
		count_reg = 16'h0002;
		direction_flag = 1'b0;
		seg_override = 1'b1;
		override_segment = 16'h3000;
		port_pointer_reg = 16'h0050;
		run(OP_BLOCK_OUT, 1'b1, 1'b1);
		chk({peer_u.port[8'h51], peer_u.port[8'h50]}, 16'h4433);
		chk(idx_cap, 16'h0044);
		chk(seg_cap, 16'h3000);
		slow = 1'b0;
		seg_override = 1'b0;
		source_index = 16'h0060;
		direction_flag = 1'b1;
		run(OP_BLOCK_OUT, 1'b0, 1'b0);
		bud(10);
		chk({8'h00, peer_u.port[8'h50]}, 16'h005e);
		chk(idx_cap, 16'h005f);
		chk(seg_cap, 16'h1000);
	endtask
	task automatic final_report;
		$display("mismatches %0d, compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		rst_b = 1'b1;
		t_in();
		t_out();
		t_bin();
		t_bout();
		final_report();
	end
	initial begin
		#1000000;
		bad_count++;
		final_report();
	end
endmodule
bind iopx_exec iopx_exec_asserts chk_u (.*);
